//--- design/acs_defines.vh
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// Reset value of the second converter control register.
`define ACS_CTL2_RST 8'h00
// Field positions inside the second converter control register.
`define ACS_ACQ_MSB 5
`define ACS_ACQ_LSB 3
`define ACS_CKS_MSB 2
`define ACS_CKS_LSB 0
// Acquisition code meaning manual acquisition.
`define ACS_ACQ_MANUAL 3'h0
// Bit conversion periods per 10-bit conversion.
`define ACS_CONV_TADS 5'h0B
// Divider terminal counts, one less than the bit period in oscillator periods.
`define ACS_DIV2_LAST 6'h01
`define ACS_DIV8_LAST 6'h07
`define ACS_DIV32_LAST 6'h1F
`define ACS_DIV4_LAST 6'h03
`define ACS_DIV16_LAST 6'h0F
`define ACS_DIV64_LAST 6'h3F
// Bit periods of programmed acquisition for codes 001 to 111.
`define ACS_ACQ1_TADS 5'h02
`define ACS_ACQ2_TADS 5'h04
`define ACS_ACQ3_TADS 5'h06
`define ACS_ACQ4_TADS 5'h08
`define ACS_ACQ5_TADS 5'h0C
`define ACS_ACQ6_TADS 5'h10
`define ACS_ACQ7_TADS 5'h14
// Oscillator period and typical RC bit conversion period, in ns.
`define ACS_OSC_PERIOD_NS 40
`define ACS_RC_TAD_NS 2500

`endif

//--- design/acs_sequencer.v
// Summary of operation
// - Programmed acquisition then automatic conversion start.
// - Acquisition field bits 5:3, 2-20 periods.
// - Code 000 converts immediately on start.
// - Acquisition field resets to 000.
// - Completion clears start, sets done, resamples.
// - No flag marks end of acquisition.
// - Conversion lasts eleven bit periods; the first may be partial with code 000.
// - Divider codes give 2,8,32,4,16,64 oscillator periods.
// - Codes x11 use internal RC clock.
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.vh"

module acs_sequencer (
    input wire sys_clk,
    input wire nrst,
    input wire [7:0] convCtrlTwo,
    input wire startReq,
    input wire doneClr,
    input wire rcOscIn,
    output reg startFlag_ff,
    output reg doneFlag_ff,
    output reg sampling_ff,
    output reg converting_ff,
    output reg tadTick_ff
);

    // Sequencer states. Idle and acquisition leave the sample-hold tracking the input;
    // only conversion holds it.
    localparam ST_IDLE = 2'b00;
    localparam ST_ACQ = 2'b01;
    localparam ST_CONV = 2'b10;

    reg [7:0] ctl2_ff;
    reg [5:0] divCnt_ff;
    reg rcSync1_ff;
    reg rcSync2_ff;
    reg rcSync3_ff;
    reg [1:0] state_ff;
    reg [4:0] tadCnt_ff;
    reg [1:0] nxt_state;
    reg [4:0] nxt_tadCnt;
    reg [5:0] divLast;
    reg convDone;
    wire [2:0] acqSel;
    wire [2:0] cksSel;
    wire useRc;
    wire divTick;
    wire rcTick;
    wire tickNow;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration capture.

    // The control byte is registered so its fields have a defined value after reset.
    // Software may rewrite the byte at any time; a clock change during a conversion
    // alters the bit period of the bits still to come.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            ctl2_ff <= `ACS_CTL2_RST;
        end else begin
            ctl2_ff <= convCtrlTwo;
        end
    end

    assign acqSel = ctl2_ff[`ACS_ACQ_MSB:`ACS_ACQ_LSB];
    assign cksSel = ctl2_ff[`ACS_CKS_MSB:`ACS_CKS_LSB];
    assign useRc = (cksSel[1:0] == 2'b11);

    ////////////////////////////////////////////////////////////////////////////
    // Bit conversion clock.

    // Terminal count of the oscillator divider, one less than the period.
    // The oscillator frequency is not checked against the chosen divider; keeping
    // the bit period inside its analog limits is left to software.
    always @* begin
        case (cksSel)
            3'h0: divLast = `ACS_DIV2_LAST;
            3'h1: divLast = `ACS_DIV8_LAST;
            3'h2: divLast = `ACS_DIV32_LAST;
            3'h4: divLast = `ACS_DIV4_LAST;
            3'h5: divLast = `ACS_DIV16_LAST;
            3'h6: divLast = `ACS_DIV64_LAST;
            default: divLast = `ACS_DIV2_LAST;
        endcase
    end

    // A free running divider; the first period after a start may be partial.
    // Restarting it at each start would align that period, at the cost of a second
    // control path into the counter; the partial first period is accepted instead.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            divCnt_ff <= 6'h00;
        end else if (divCnt_ff >= divLast) begin
            divCnt_ff <= 6'h00;
        end else begin
            divCnt_ff <= divCnt_ff + 6'h01;
        end
    end

    assign divTick = (divCnt_ff >= divLast);

    // The RC oscillator is asynchronous, so it is synchronised before edge detection.
    // The chain keeps running through reset, so the edge detector already holds the
    // level of the pin when reset ends and no false edge follows a reset.
    always @(posedge sys_clk) begin
        rcSync1_ff <= rcOscIn;
        rcSync2_ff <= rcSync1_ff;
        rcSync3_ff <= rcSync2_ff;
    end

    // Each rising RC edge is one bit period; RC must run well below sys_clk/2.
    // RC periods shorter than about two system clocks are lost, since each high and low
    // level must be caught by at least one synchroniser sample to be seen.
    assign rcTick = rcSync2_ff & ~rcSync3_ff;
    assign tickNow = useRc ? rcTick : divTick;

    ////////////////////////////////////////////////////////////////////////////
    // Acquisition and conversion sequencer.

    // Number of bit periods for a programmed acquisition code.
    // Code 000 never reaches here; the default only keeps the case complete.
    function [4:0] acqTads;
        input [2:0] code;
        begin
            case (code)
                3'h1: acqTads = `ACS_ACQ1_TADS;
                3'h2: acqTads = `ACS_ACQ2_TADS;
                3'h3: acqTads = `ACS_ACQ3_TADS;
                3'h4: acqTads = `ACS_ACQ4_TADS;
                3'h5: acqTads = `ACS_ACQ5_TADS;
                3'h6: acqTads = `ACS_ACQ6_TADS;
                3'h7: acqTads = `ACS_ACQ7_TADS;
                default: acqTads = `ACS_ACQ1_TADS;
            endcase
        end
    endfunction

    // Next state; a start while busy is ignored because the flag is already set.
    // Completion returns to idle, where a start is honoured on the next edge, so a
    // start held high through completion begins a fresh conversion.
    always @* begin
        nxt_state = state_ff;
        nxt_tadCnt = tadCnt_ff;
        convDone = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (startReq) begin
                    if (acqSel == `ACS_ACQ_MANUAL) begin
                        nxt_state = ST_CONV;
                        nxt_tadCnt = `ACS_CONV_TADS;
                    end else begin
                        nxt_state = ST_ACQ;
                        nxt_tadCnt = acqTads(acqSel);
                    end
                end
            end
            ST_ACQ: begin
                // Only sampling_ff and converting_ff change here, so no flag marks acquisition end.
                if (tickNow) begin
                    if (tadCnt_ff == 5'h01) begin
                        nxt_state = ST_CONV;
                        nxt_tadCnt = `ACS_CONV_TADS;
                    end else begin
                        nxt_tadCnt = tadCnt_ff - 5'h01;
                    end
                end
            end
            ST_CONV: begin
                if (tickNow) begin
                    if (tadCnt_ff == 5'h01) begin
                        nxt_state = ST_IDLE;
                        nxt_tadCnt = 5'h00;
                        convDone = 1'b1;
                    end else begin
                        nxt_tadCnt = tadCnt_ff - 5'h01;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_tadCnt = 5'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Sequencer registers and status outputs.
    // The start, sampling and converting ports come straight from flip-flops and follow
    // the next state, so they change on the same edge as the state register.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            tadCnt_ff <= 5'h00;
            startFlag_ff <= 1'b0;
            doneFlag_ff <= 1'b0;
            sampling_ff <= 1'b1;
            converting_ff <= 1'b0;
            tadTick_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tadCnt_ff <= nxt_tadCnt;
            tadTick_ff <= tickNow;
            // Start flag stays set through acquisition and conversion.
            startFlag_ff <= (nxt_state != ST_IDLE);
            // Completion wins over a clear in the same cycle.
            if (convDone) begin
                doneFlag_ff <= 1'b1;
            end else if (doneClr) begin
                doneFlag_ff <= 1'b0;
            end
            sampling_ff <= (nxt_state != ST_CONV);
            converting_ff <= (nxt_state == ST_CONV);
        end
    end

endmodule

`default_nettype wire

//--- testbench/acs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module acs_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] convCtrlTwo,
    input wire logic startReq,
    input wire logic doneClr,
    input wire logic startFlag_ff,
    input wire logic doneFlag_ff,
    input wire logic sampling_ff,
    input wire logic converting_ff,
    input wire logic tadTick_ff
);
    logic [4:0] tickCnt_ff;
    logic busyDly_ff;
    logic [2:0] acqCfg_ff;
    logic [2:0] acqUsed_ff;
    // Bit periods of acquisition for each acquisition code.
    function automatic [4:0] acqLen(input logic [2:0] a);
        acqLen = (a < 3'h5) ? {1'b0, a, 1'b0} : {a, 2'b00} - 5'h08;
    endfunction
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Ticks are counted one cycle late, so a tick seen just after start belongs to idle time.
    always @(posedge sys_clk) begin
        busyDly_ff <= startFlag_ff;
        tickCnt_ff <= startFlag_ff ? tickCnt_ff + {4'h0, tadTick_ff & busyDly_ff} : 5'h00;
    end
    // The acquisition field as the block holds it: one cycle behind the port, 000 after reset.
    always @(posedge sys_clk) begin
        acqCfg_ff <= nrst ? convCtrlTwo[5:3] : 3'h0;
        if (!startFlag_ff) begin
            acqUsed_ff <= acqCfg_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_start_take: assert property (startReq && !startFlag_ff |=> startFlag_ff) else $error("Start lost.");
    chk_manual_go: assert property (startReq && !startFlag_ff && convCtrlTwo[5:3] == 3'h0
        && $stable(convCtrlTwo) |=> converting_ff) else $error("No direct conversion.");
    chk_acq_span: assert property ($rose(converting_ff) && $past(startFlag_ff)
        |-> tadTick_ff && tickCnt_ff == acqLen(acqUsed_ff) - 5'h01) else $error("Bad acquisition.");
    chk_conv_span: assert property ($fell(startFlag_ff)
        |-> tadTick_ff && tickCnt_ff == acqLen(acqUsed_ff) + 5'h0A) else $error("Bad conversion.");
    chk_done_set: assert property ($fell(startFlag_ff) |-> doneFlag_ff && sampling_ff) else $error("Bad end.");
    chk_done_cause: assert property ($rose(doneFlag_ff) |-> $fell(startFlag_ff)) else $error("Stray done.");
    chk_done_hold: assert property (doneFlag_ff && !doneClr |=> doneFlag_ff) else $error("Done lost.");
    chk_conv_busy: assert property (converting_ff |-> startFlag_ff && !sampling_ff) else $error("Bad phase.");
    chk_acq_sample: assert property (startFlag_ff && !converting_ff |-> sampling_ff) else $error("No sampling.");
endmodule
bind acs_sequencer acs_checker chk (.sys_clk, .nrst, .convCtrlTwo, .startReq, .doneClr, .startFlag_ff,
    .doneFlag_ff, .sampling_ff, .converting_ff, .tadTick_ff);
`default_nettype wire

//--- testbench/acs_rc_source.sv
`timescale 1ns/1ns
`default_nettype none
module acs_rc_source #(parameter int HalfNs = 1250) (
    output var logic rcOscIn
);
    // Free-running source; the 7 ns offset keeps its edges off the system clock edges.
    // It runs on by itself, as the RC clock does while the core sleeps through a conversion.
    initial begin
        rcOscIn = 1'b0;
        #7;
        forever #(HalfNs) rcOscIn = ~rcOscIn;
    end
endmodule
`default_nettype wire

//--- testbench/adc_acquisition_clock_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module adc_acquisition_clock_sequencer_test;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic startReq = 1'b0;
    logic doneClr = 1'b0;
    logic [7:0] convCtrlTwo = 8'h00;
    wire rcOscIn, startFlag_ff, doneFlag_ff, sampling_ff, converting_ff, tadTick_ff;
    wire [3:0] flags = {startFlag_ff, doneFlag_ff, sampling_ff, converting_ff};
    int n_mismatch = 0;
    int n_tests = 0;
    // Every clock code is visited; the oscillator limits per code are analog limits, so only sequencing is judged.
    int pv [8] = '{2, 8, 32, 4, 16, 64, 63, 63};
    logic [2:0] ck [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
    // The watchdog allows about three times the expected run.
    initial forever #20 sys_clk = ~sys_clk;
    initial begin
        #800000 n_mismatch++;
        give_verdict;
    end
    acs_rc_source rc (.rcOscIn);
    acs_sequencer uut (.sys_clk, .nrst, .convCtrlTwo, .startReq, .doneClr, .rcOscIn, .startFlag_ff,
        .doneFlag_ff, .sampling_ff, .converting_ff, .tadTick_ff);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %b not %b", $time, got, exp);
        end
    endtask
    task automatic check_span(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("Error %0t: span %0d outside %0d to %0d", $time, got, lo, hi);
        end
    endtask
    // One conversion; a start inside the busy span must be ignored.
    task automatic t_conv(input logic [2:0] acq, input logic [2:0] cks, input int p);
        int n;
        int na;
        na = (acq < 5) ? 2 * acq : 4 * acq - 8;
        step(1);
        convCtrlTwo <= {2'b00, acq, cks};
        step(2);
        startReq <= 1'b1;
        step(1);
        startReq <= 1'b0;
        #1 check(flags, {2'b10, acq != 3'h0, acq == 3'h0});
        for (n = 1; startFlag_ff === 1'b1 && n < 4000; n++) begin
            step(1);
            startReq <= (n == 3);
            #1;
        end
        check_span(n, (na + 10) * (p - 1), (na + 11) * p + 4);
        check(flags, 4'b0110);
        step(1);
        doneClr <= 1'b1;
        step(1);
        doneClr <= 1'b0;
        #1 check(flags, 4'b0010);
        $display("Conversion acq %0d clk %0d done", acq, cks);
    endtask
    // Reset with a programmed code on the port; the cleared field makes the first start convert at once.
    task automatic t_reset(input int cycles);
        int n;
        nrst <= 1'b0;
        convCtrlTwo <= 8'h38;
        step(cycles);
        nrst <= 1'b1;
        startReq <= 1'b1;
        #1 check(flags, 4'b0010);
        step(1);
        startReq <= 1'b0;
        #1 check(flags, 4'b1001);
        for (n = 1; startFlag_ff === 1'b1 && n < 100; n++) begin
            step(1);
            #1;
        end
        check_span(n, 22, 23);
        check(flags, 4'b0110);
        step(1);
        doneClr <= 1'b1;
        step(1);
        doneClr <= 1'b0;
        #1 check(flags, 4'b0010);
        $display("Reset over %0d cycles done", cycles);
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        t_reset(6);
        for (int i = 0; i < 8; i++) t_conv(i[2:0], ck[i], pv[i]);
        step(1);
        t_reset(3);
        give_verdict;
    end
endmodule
`default_nettype wire
